// ### src/bir_ctrl.sv
module bir_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [bir_pkg::LEVELS-1:0] i_req,
  input wire logic [bir_pkg::LEVELS-1:0] i_mask,
  input wire logic [bir_pkg::VEC_BASE_W-1:0] i_vector_base,
  input wire logic i_cascade_en,
  input wire logic i_ack,
  input wire logic i_eoi,
  output logic o_int,
  output logic [bir_pkg::VEC_W-1:0] o_vec,
  output logic o_vec_valid,
  output logic o_cascade
);
  import bir_pkg::*;

  logic [LEVELS-1:0] in_service_reg;
  logic [LEVELS-1:0] pending;
  logic [LVL_W-1:0] pend_lvl;
  logic [LVL_W-1:0] isr_lvl;
  logic any_pend;
  logic any_isr;

  // Level 0 is highest priority
  always_comb begin
    pending = i_req & ~i_mask;
    pend_lvl = '0;
    isr_lvl = '0;
    any_pend = 1'b0;
    any_isr = 1'b0;
    for (int i = LEVELS - 1; i >= 0; i--) begin
      if (pending[i]) begin
        pend_lvl = LVL_W'(i);
        any_pend = 1'b1;
      end
      if (in_service_reg[i]) begin
        isr_lvl = LVL_W'(i);
        any_isr = 1'b1;
      end
    end
    o_int = any_pend && (!any_isr || pend_lvl < isr_lvl);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      in_service_reg <= '0;
    end else if (i_clk_en) begin
      if (i_eoi && any_isr) begin
        in_service_reg[isr_lvl] <= 1'b0;
      end
      // Taking a level wins over a same-cycle end of service
      if (i_ack && o_int) begin
        in_service_reg[pend_lvl] <= 1'b1;
      end
    end
  end

  // Request withdrawn before the acknowledge gives the spurious level
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_vec <= '0;
      o_vec_valid <= 1'b0;
      o_cascade <= 1'b0;
    end else if (i_clk_en) begin
      o_vec_valid <= i_ack;
      o_cascade <= i_ack && o_int && i_cascade_en && pend_lvl == CASCADE_LEVEL;
      if (i_ack) begin
        o_vec <= {i_vector_base, o_int ? pend_lvl : SPURIOUS_LEVEL};
      end
    end
  end
endmodule // bir_ctrl

// ### src/bir_pkg.sv
package bir_pkg;
  localparam int LEVELS = 8;
  localparam int LVL_W = 3;
  localparam int SEL_W = 4;
  localparam int SRC_N = 16;
  localparam int VEC_BASE_W = 5;
  localparam int VEC_W = 8;
  localparam int SYNC_STAGES = 3;

  // Pin inputs entering the synchronisers, by position
  localparam int PIN_N = 15;
  localparam int PIN_BUS0 = 0;
  localparam int PIN_TIMER0 = 8;
  localparam int PIN_TIMER1 = 9;
  localparam int PIN_RX = 10;
  localparam int PIN_TX = 11;
  localparam int PIN_PFAIL = 12;
  localparam int PIN_RING = 13;
  localparam int PIN_TIMEOUT = 14;
  // Bus lines idle high, everything else idles low
  localparam logic [PIN_N-1:0] PIN_RESET = 15'h00ff;

  // Routing matrix source codes
  localparam logic [SEL_W-1:0] SRC_NONE = 4'h0;
  localparam logic [SEL_W-1:0] SRC_BUS0 = 4'h1;
  localparam logic [SEL_W-1:0] SRC_TIMEOUT = 4'h9;
  localparam logic [SEL_W-1:0] SRC_RX = 4'ha;
  localparam logic [SEL_W-1:0] SRC_TX = 4'hb;
  localparam logic [SEL_W-1:0] SRC_PFAIL = 4'hc;
  localparam logic [SEL_W-1:0] SRC_RING = 4'hd;
  localparam logic [SEL_W-1:0] SRC_PARITY = 4'he;

  // Hard-wired levels
  localparam logic [LVL_W-1:0] MASTER_TIMER_LEVEL = 3'h0;
  localparam logic [LVL_W-1:0] CASCADE_LEVEL = 3'h7;
  localparam logic [LVL_W-1:0] SLAVE_TIMER_LEVEL = 3'h5;
  localparam logic [LVL_W-1:0] SPURIOUS_LEVEL = 3'h7;

  // Selector nibble n: n<8 master level n, n>=8 slave level n-8
  localparam logic [2*LEVELS*SEL_W-1:0] DEFAULT_ROUTE = 64'h0000_0087_0065_4320;

  localparam logic [SEL_W-1:0] DEFAULT_NMI_SEL = 4'hc;
endpackage

// ### src/bir_route.sv
module bir_route (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [7:0] i_bus_irq_line_n,
  input wire logic i_interval_timer0,
  input wire logic i_interval_timer1,
  input wire logic i_serial_rx_ready_flag,
  input wire logic i_serial_tx_ready_flag,
  input wire logic i_power_fail,
  input wire logic i_ring_indicator,
  input wire logic i_bus_timeout,
  input wire logic i_parity_err,
  input wire logic i_parity_clr,
  input wire logic i_sw_irq_wr,
  input wire logic i_sw_irq_data,
  input wire logic [2*bir_pkg::LEVELS*bir_pkg::SEL_W-1:0] i_route_sel,
  input wire logic [bir_pkg::SEL_W-1:0] i_nmi_sel,
  input wire logic [bir_pkg::LEVELS-1:0] i_master_mask,
  input wire logic [bir_pkg::LEVELS-1:0] i_slave_mask,
  input wire logic [bir_pkg::VEC_BASE_W-1:0] i_master_base,
  input wire logic [bir_pkg::VEC_BASE_W-1:0] i_slave_base,
  input wire logic i_int_ack,
  input wire logic i_master_eoi,
  input wire logic i_slave_eoi,
  output logic o_cpu_irq,
  output logic o_cpu_nmi,
  output logic [bir_pkg::VEC_W-1:0] o_vector,
  output logic o_vector_valid,
  output logic o_bus_sw_irq_out,
  output logic o_bus_parity_irq_out
);
  import bir_pkg::*;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_s1_reg;
  logic [PIN_N-1:0] pin_s2_reg;
  logic [PIN_N-1:0] pin_s3_reg;
  logic [PIN_N-1:0] pin_reg;
  logic [SRC_N-1:0] src;
  logic [LEVELS-1:0] m_req;
  logic [LEVELS-1:0] s_req;
  logic m_int;
  logic s_int;
  logic [VEC_W-1:0] m_vec;
  logic [VEC_W-1:0] s_vec;
  logic m_vec_valid;
  logic s_vec_valid;
  logic m_cascade;
  logic parity_reg;

  assign pin_raw = {i_bus_timeout, i_ring_indicator, i_power_fail, i_serial_tx_ready_flag,
                    i_serial_rx_ready_flag, i_interval_timer1, i_interval_timer0,
                    i_bus_irq_line_n};

  // Three stages; a change is taken once stages two and three agree
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pin_s1_reg <= PIN_RESET;
      pin_s2_reg <= PIN_RESET;
      pin_s3_reg <= PIN_RESET;
      pin_reg <= PIN_RESET;
    end else if (i_clk_en) begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < PIN_N; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  // Matrix sources; code 0 and code 15 tie low
  always_comb begin
    src = '0;
    for (int b = 0; b < 8; b++) begin
      src[int'(SRC_BUS0) + b] = ~pin_reg[PIN_BUS0 + b];
    end
    src[SRC_TIMEOUT] = pin_reg[PIN_TIMEOUT];
    src[SRC_RX] = pin_reg[PIN_RX];
    src[SRC_TX] = pin_reg[PIN_TX];
    src[SRC_PFAIL] = pin_reg[PIN_PFAIL];
    src[SRC_RING] = pin_reg[PIN_RING];
    src[SRC_PARITY] = parity_reg;
  end

  // Selectors are static; the default routing is DEFAULT_ROUTE
  generate
    for (genvar lv = 0; lv < LEVELS; lv++) begin : g_level
      if (lv == int'(MASTER_TIMER_LEVEL)) begin : g_m_timer
        assign m_req[lv] = pin_reg[PIN_TIMER0];
      end else if (lv == int'(CASCADE_LEVEL)) begin : g_m_casc
        assign m_req[lv] = s_int;
      end else begin : g_m_sel
        assign m_req[lv] = src[i_route_sel[lv*SEL_W +: SEL_W]];
      end
      if (lv == int'(SLAVE_TIMER_LEVEL)) begin : g_s_timer
        assign s_req[lv] = pin_reg[PIN_TIMER1];
      end else begin : g_s_sel
        assign s_req[lv] = src[i_route_sel[(LEVELS+lv)*SEL_W +: SEL_W]];
      end
    end
  endgenerate

  // Master acknowledge cascade pulse is the slave's acknowledge
  bir_ctrl u_master (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_req(m_req),
    .i_mask(i_master_mask),
    .i_vector_base(i_master_base),
    .i_cascade_en(1'b1),
    .i_ack(i_int_ack),
    .i_eoi(i_master_eoi),
    .o_int(m_int),
    .o_vec(m_vec),
    .o_vec_valid(m_vec_valid),
    .o_cascade(m_cascade)
  );

  bir_ctrl u_slave (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_req(s_req),
    .i_mask(i_slave_mask),
    .i_vector_base(i_slave_base),
    .i_cascade_en(1'b0),
    .i_ack(m_cascade),
    .i_eoi(i_slave_eoi),
    .o_int(s_int),
    .o_vec(s_vec),
    .o_vec_valid(s_vec_valid),
    .o_cascade()
  );

  // No path accepts a vector from the bus
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_vector <= '0;
      o_vector_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_vector_valid <= (m_vec_valid && !m_cascade) || s_vec_valid;
      if (s_vec_valid) begin
        o_vector <= s_vec;
      end else if (m_vec_valid && !m_cascade) begin
        o_vector <= m_vec;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_cpu_irq <= 1'b0;
      o_cpu_nmi <= 1'b0;
    end else if (i_clk_en) begin
      o_cpu_irq <= m_int;
      o_cpu_nmi <= src[i_nmi_sel];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_bus_sw_irq_out <= 1'b0;
    end else if (i_clk_en && i_sw_irq_wr) begin
      o_bus_sw_irq_out <= i_sw_irq_data;
    end
  end

  // Sticky until cleared; a new error wins over the clear
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      parity_reg <= 1'b0;
      o_bus_parity_irq_out <= 1'b0;
    end else if (i_clk_en) begin
      parity_reg <= i_parity_err || (parity_reg && !i_parity_clr);
      o_bus_parity_irq_out <= i_parity_err || (parity_reg && !i_parity_clr);
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset || !i_clk_en);

  a_slave_to_level7: assert property (m_req[7] == s_int)
    else $error("slave output not on master level 7");
  a_timer0_level: assert property (m_req[0] == pin_reg[PIN_TIMER0])
    else $error("timer 0 not on master level 0");
  a_timer1_level: assert property (s_req[5] == pin_reg[PIN_TIMER1])
    else $error("timer 1 not on slave level 5");
  a_bus_line_inverted: assert property (
    i_route_sel[SEL_W +: SEL_W] == 4'h2 |-> m_req[1] == !pin_reg[PIN_BUS0 + 1])
    else $error("bus line not inverted onto master level 1");
  a_unselected_quiet: assert property (
    i_route_sel[6*SEL_W +: SEL_W] == SRC_NONE |-> !m_req[6])
    else $error("unselected level active");
  a_cpu_irq_master: assert property (##1 o_cpu_irq == $past(m_int))
    else $error("cpu request not from master");
  a_master_vector: assert property (
    i_int_ack && !(m_int && m_req[7] && !i_master_mask[7] &&
                   !(|(m_req[6:0] & ~i_master_mask[6:0])))
    |-> ##2 o_vector_valid && o_vector[7:3] == $past(i_master_base, 2))
    else $error("master vector late or wrong");
  a_slave_vector: assert property (
    m_cascade |-> !o_vector_valid ##2 o_vector_valid ##0 o_vector[7:3] == i_slave_base)
    else $error("slave vector late or wrong");
  a_sw_irq_follow: assert property (
    i_sw_irq_wr |=> o_bus_sw_irq_out == $past(i_sw_irq_data))
    else $error("software bus interrupt not updated");
  a_parity_sticky: assert property (
    i_parity_err |=> o_bus_parity_irq_out ##1 (o_bus_parity_irq_out || $past(i_parity_clr)))
    else $error("parity interrupt not held");
  a_nmi_route: assert property (##1 o_cpu_nmi == $past(src[i_nmi_sel]))
    else $error("nmi not from selected source");

  c_master_ack: cover property (i_int_ack && m_int ##2 o_vector_valid);
  c_slave_ack: cover property (m_cascade ##2 o_vector_valid);
  c_parity_clear: cover property (o_bus_parity_irq_out && i_parity_clr ##1 !parity_reg);
  c_nmi_fire: cover property (!o_cpu_nmi ##1 o_cpu_nmi);
endmodule // bir_route

// ### tb/bir_cpu_model.sv
module bir_cpu_model (
  input wire logic i_sys_clk,
  input wire logic i_vector_valid,
  input wire logic [bir_pkg::VEC_W-1:0] i_vector,
  output logic o_int_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  import bir_pkg::*;

  initial o_int_ack = 1'b0;

  // One-cycle acknowledge, then a bounded wait for the vector
  task automatic take_int(output logic [VEC_W-1:0] vec, output int lat);
    lat = -1;
    vec = '0;
    @(posedge i_sys_clk);
    o_int_ack <= 1'b1;
    @(posedge i_sys_clk);
    o_int_ack <= 1'b0;
    for (int k = 1; k <= 8 && lat < 0; k++) begin
      @(posedge i_sys_clk);
      if (i_vector_valid === 1'b1) begin
        lat = k;
        vec = i_vector;
      end
    end
  endtask
endmodule // bir_cpu_model

// ### tb/bir_route_test.sv
module bir_route_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bir_pkg::*;

  localparam logic [4:0] MB = 5'h15;
  localparam logic [4:0] SB = 5'h0a;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [PIN_N-1:0] pins = PIN_RESET;
  logic perr = 1'b0;
  logic pclr = 1'b0;
  logic sw_wr = 1'b0;
  logic sw_data = 1'b0;
  logic [2*LEVELS*SEL_W-1:0] route_sel = DEFAULT_ROUTE;
  logic [SEL_W-1:0] nmi_sel = SRC_NONE;
  logic meoi = 1'b0;
  logic seoi = 1'b0;
  logic int_ack;
  logic cpu_irq, cpu_nmi, vector_valid, sw_out, par_out;
  logic [VEC_W-1:0] vector;
  int err_count = 0;
  int check_count = 0;

  bir_route u_bir_route (
    .i_sys_clk(sys_clk), .i_reset(reset), .i_clk_en(clk_en),
    .i_bus_irq_line_n(pins[7:0]), .i_interval_timer0(pins[PIN_TIMER0]),
    .i_interval_timer1(pins[PIN_TIMER1]), .i_serial_rx_ready_flag(pins[PIN_RX]),
    .i_serial_tx_ready_flag(pins[PIN_TX]), .i_power_fail(pins[PIN_PFAIL]),
    .i_ring_indicator(pins[PIN_RING]), .i_bus_timeout(pins[PIN_TIMEOUT]),
    .i_parity_err(perr), .i_parity_clr(pclr), .i_sw_irq_wr(sw_wr),
    .i_sw_irq_data(sw_data), .i_route_sel(route_sel), .i_nmi_sel(nmi_sel),
    .i_master_mask(8'h00), .i_slave_mask(8'hdc), .i_master_base(MB),
    .i_slave_base(SB), .i_int_ack(int_ack), .i_master_eoi(meoi),
    .i_slave_eoi(seoi), .o_cpu_irq(cpu_irq), .o_cpu_nmi(cpu_nmi),
    .o_vector(vector), .o_vector_valid(vector_valid),
    .o_bus_sw_irq_out(sw_out), .o_bus_parity_irq_out(par_out)
  );

  bir_cpu_model u_bir_cpu_model (
    .i_sys_clk(sys_clk), .i_vector_valid(vector_valid),
    .i_vector(vector), .o_int_ack(int_ack)
  );

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus lines are active low at the pin
  task automatic drive(input int pin, input logic on);
    @(posedge sys_clk);
    pins[pin] <= (pin < 8) ? !on : on;
  endtask

  task automatic pulse_eoi(input logic slv);
    @(posedge sys_clk);
    seoi <= slv;
    meoi <= !slv;
    @(posedge sys_clk);
    seoi <= 1'b0;
    meoi <= 1'b0;
  endtask

  task automatic t_irq(input int pin, input logic slv, input logic [2:0] lvl);
    logic [VEC_W-1:0] v;
    int lat;
    drive(pin, 1'b1);
    repeat (7) @(posedge sys_clk);
    chk_bit("cpu_irq", 1'b1, cpu_irq);
    u_bir_cpu_model.take_int(v, lat);
    chk_val("vector", {slv ? SB : MB, lvl}, v);
    chk_val("latency", slv ? 8'h03 : 8'h02, 8'(lat));
    drive(pin, 1'b0);
    // Slave first, so the master never frees level 7 early
    if (slv) pulse_eoi(1'b1);
    pulse_eoi(1'b0);
    repeat (8) @(posedge sys_clk);
    chk_bit("cpu_irq idle", 1'b0, cpu_irq);
  endtask

  task automatic t_nmi(input logic [SEL_W-1:0] code, input int pin);
    nmi_sel <= code;
    drive(pin, 1'b1);
    repeat (7) @(posedge sys_clk);
    chk_bit("cpu_nmi on", 1'b1, cpu_nmi);
    drive(pin, 1'b0);
    repeat (7) @(posedge sys_clk);
    chk_bit("cpu_nmi off", 1'b0, cpu_nmi);
  endtask

  task automatic t_outgoing();
    logic [VEC_W-1:0] v;
    int lat;
    u_bir_cpu_model.take_int(v, lat);
    chk_val("spurious", {MB, SPURIOUS_LEVEL}, v);
    for (int d = 1; d >= 0; d--) begin
      @(posedge sys_clk);
      sw_wr <= 1'b1;
      sw_data <= d[0];
      @(posedge sys_clk);
      sw_wr <= 1'b0;
      @(posedge sys_clk);
      chk_bit("sw_irq", d[0], sw_out);
    end
    perr <= 1'b1;
    nmi_sel <= SRC_PARITY;
    @(posedge sys_clk);
    perr <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_bit("parity sticky", 1'b1, par_out);
    chk_bit("parity nmi", 1'b1, cpu_nmi);
    pclr <= 1'b1;
    @(posedge sys_clk);
    pclr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk_bit("parity clear", 1'b0, par_out);
  endtask

  // Enable low must freeze the software interrupt latch
  task automatic t_freeze();
    @(posedge sys_clk);
    clk_en <= 1'b0;
    sw_wr <= 1'b1;
    sw_data <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_bit("sw_irq frozen", 1'b0, sw_out);
    clk_en <= 1'b1;
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk_bit("irq after reset", 1'b0, cpu_irq);
    t_irq(PIN_TIMER0, 1'b0, MASTER_TIMER_LEVEL);
    for (int n = 1; n <= 5; n++) t_irq(n, 1'b0, 3'(n));
    t_irq(6, 1'b1, 3'h0);
    t_irq(7, 1'b1, 3'h1);
    t_irq(PIN_TIMER1, 1'b1, SLAVE_TIMER_LEVEL);
    drive(PIN_BUS0, 1'b1);
    repeat (8) @(posedge sys_clk);
    chk_bit("unrouted quiet", 1'b0, cpu_irq);
    drive(PIN_BUS0, 1'b0);
    route_sel[27:24] <= SRC_RX;
    t_irq(PIN_RX, 1'b0, 3'h6);
    route_sel[27:24] <= SRC_TIMEOUT;
    t_irq(PIN_TIMEOUT, 1'b0, 3'h6);
    t_nmi(SRC_PFAIL, PIN_PFAIL);
    t_nmi(SRC_TX, PIN_TX);
    t_nmi(SRC_RING, PIN_RING);
    t_nmi(SRC_BUS0, PIN_BUS0);
    t_outgoing();
    t_freeze();
    report_and_stop();
  end

  // Whole run is about 360 cycles
  initial begin
    #40000;
    err_count++;
    report_and_stop();
  end
endmodule // bir_route_test
